//--- src/stc_core.sv
// Slow tick counter core: oscillator gate, counter, load sequencer, pulse output and register port
//
// What this block does
// [R1] Divide oscillator down to one tick per 32 seconds; tick increments 24-bit counter.
// [R2] Counter wraps from all ones to zero.
// [R3] Counter clears to zero at power-on.
// [R4] During a bus access the counter freezes; one tick is held and applied later.
// [R5] A load changes only the bytes received, high byte first.
// [R6] Counter does not advance while a load writes it.
// [R7] Divider halt clears stages two and three; stage one keeps running.
// [R8] Loads are accepted whether or not the divider is halted.
// [R9] No new ticks while the divider is halted; a tick already due or held is still applied.
// [R10] First tick after release may come up to one 8192 Hz period early.
// [R11] One interrupt pulse per increment, aligned with it, while clock echo is off.
// [R12] New counter value is readable when the pulse appears.
// [R13] Clock echo puts the oscillator square wave on the interrupt output.
// [R14] Deep sleep stops the oscillator and all ticks and pulses.
// [R15] Bus side still answers instructions in deep sleep.
// [R16] Bus commands reach divider and counter logic safely synchronised.
// [R17] Master reads in short bursts with a stop between reads.
// [R18] Master ends each access within 32 seconds or ticks are lost.
// [R19] Fast mode code 41h advances once per second; 40h disables it.
// [R20] Code 11h stops and clears divider, 10h restarts; first tick after a full period less up to three oscillator edges.
// [R21] Load code 80h then up to three bytes: bits 23:16, 15:8, 7:0.
// [R22] Sleep codes 21h/20h; clock echo codes 31h/30h.
// [R23] Interrupt pulse lasts until the next oscillator edge, starting with the increment.
// [R24] Counter survives deep sleep; counting resumes once oscillator runs again.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`include "stc_map.svh"

module stc_core #(
    parameter int COUNT_W = `STC_COUNT_W,
    parameter int ADDR_W  = `STC_ADDR_W,
    parameter int DATA_W  = `STC_DATA_W
) (
    input  wire logic              ref_clk,     // System clock, 50 MHz
    input  wire logic              reset,       // Synchronous reset, active high
    input  wire logic              crystal_in,  // Oscillator input level
    output logic                   crystal_out, // Oscillator drive, low when stopped
    output logic                   int_out,     // Wake pulse or echoed oscillator
    input  wire logic [ADDR_W-1:0] bus_addr,    // Register address
    input  wire logic [DATA_W-1:0] bus_wdata,   // Write data
    input  wire logic              bus_wr,      // Write strobe
    input  wire logic              bus_rd,      // Read strobe
    output logic [DATA_W-1:0]      bus_rdata    // Read data, cycle after strobe
);

    stc_pkg::stc_mode_t mode;
    stc_pkg::stc_mode_t next_mode;
    stc_pkg::stc_load_t load_state;
    stc_pkg::stc_load_t next_load_state;

    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;
    logic               pending;
    logic               session;
    logic               osc_level;
    logic               pulse;
    logic               next_pulse;
    logic               tick;
    logic [7:0]         instr;

    // Replace one byte lane of the counter
    function automatic logic [COUNT_W-1:0] merge_byte(
        input logic [COUNT_W-1:0] cur,
        input logic [7:0]         val,
        input int                 lsb
    );
        logic [COUNT_W-1:0] mask;
        logic [COUNT_W-1:0] ins;
        mask = COUNT_W'(8'hFF) << lsb;
        ins  = COUNT_W'(val) << lsb;
        merge_byte = (cur & ~mask) | ins;
    endfunction : merge_byte

    // Address match shared by both strobes
    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        hit = (addr == ofs);
    endfunction : hit

    wire wr_instr   = bus_wr && hit(bus_addr, ADDR_W'(`STC_OFS_INSTR));
    wire wr_param   = bus_wr && hit(bus_addr, ADDR_W'(`STC_OFS_PARAM));
    wire wr_session = bus_wr && hit(bus_addr, ADDR_W'(`STC_OFS_SESSION));
    wire rd_count   = bus_rd && hit(bus_addr, ADDR_W'(`STC_OFS_COUNT));
    wire rd_status  = bus_rd && hit(bus_addr, ADDR_W'(`STC_OFS_STATUS));
    wire rd_session = bus_rd && hit(bus_addr, ADDR_W'(`STC_OFS_SESSION));
    wire rd_instr   = bus_rd && hit(bus_addr, ADDR_W'(`STC_OFS_INSTR));

    assign instr = bus_wdata[7:0];

    wire load_byte = wr_param && (load_state != stc_pkg::LD_IDLE)
                     && (load_state != stc_pkg::LD_DONE);

    // Any open session, load byte write or counter read freezes the counter
    wire busy = session || load_byte || rd_count; // [R4] [R6]

    // Oscillator edges: the sampled pin is gated off entirely in deep sleep
    wire osc_edge = crystal_in && !osc_level && !mode.sleep; // [R14]

    wire inc_req = tick || pending;
    // A tick due in deep sleep is held too, so the counter stays put until the oscillator runs
    wire hold    = busy || mode.sleep; // [R24] [R14]
    wire do_inc  = inc_req && !hold;

    stc_prescaler #(
        .S1_BITS (`STC_S1_BITS),
        .S2_BITS (`STC_S2_BITS),
        .S3_BITS (`STC_S3_BITS)
    ) u_prescaler (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .osc_edge (osc_edge),
        .halt     (mode.halt),
        .fast     (mode.fast),
        .tick     (tick)
    );

    // Instruction decode; keeps working in deep sleep so the master can wake the device
    always_comb
    begin
        next_mode = mode;
        if (wr_instr)
        begin
            case (instr)
                `STC_CODE_DIV_STOP:  next_mode.halt  = 1'b1; // [R20]
                `STC_CODE_DIV_RUN:   next_mode.halt  = 1'b0; // [R20]
                `STC_CODE_SLEEP_ON:  next_mode.sleep = 1'b1; // [R22] [R15]
                `STC_CODE_SLEEP_OFF: next_mode.sleep = 1'b0; // [R22] [R15]
                `STC_CODE_ECHO_ON:   next_mode.echo  = 1'b1; // [R22]
                `STC_CODE_ECHO_OFF:  next_mode.echo  = 1'b0; // [R22]
                `STC_CODE_FAST_ON:   next_mode.fast  = 1'b1; // [R19]
                `STC_CODE_FAST_OFF:  next_mode.fast  = 1'b0; // [R19]
                default:             next_mode       = mode;
            endcase
        end
    end

    // Load sequencer: bytes arrive high, mid, low; extra bytes are dropped
    always_comb
    begin
        next_load_state = load_state;
        if (wr_instr)
            next_load_state = (instr == `STC_CODE_LOAD) ? stc_pkg::LD_HIGH : stc_pkg::LD_IDLE; // [R21]
        else if (wr_session && !bus_wdata[`STC_SESSION_BIT])
            next_load_state = stc_pkg::LD_IDLE; // [R5]
        else if (wr_param)
        begin
            case (load_state)
                stc_pkg::LD_HIGH: next_load_state = stc_pkg::LD_MID;
                stc_pkg::LD_MID:  next_load_state = stc_pkg::LD_LOW;
                stc_pkg::LD_LOW:  next_load_state = stc_pkg::LD_DONE;
                stc_pkg::LD_DONE: next_load_state = stc_pkg::LD_DONE;
                default:          next_load_state = stc_pkg::LD_IDLE;
            endcase
        end
    end

    // Counter: a load wins over an increment; halt state does not block a load
    always_comb
    begin
        next_count = count;
        if (load_byte)
        begin
            case (load_state)
                stc_pkg::LD_HIGH: next_count = merge_byte(count, instr, `STC_HIGH_LSB); // [R5] [R8] [R21]
                stc_pkg::LD_MID:  next_count = merge_byte(count, instr, `STC_MID_LSB);  // [R5] [R21]
                stc_pkg::LD_LOW:  next_count = merge_byte(count, instr, `STC_LOW_LSB);  // [R5] [R21]
                default:          next_count = count;
            endcase
        end
        else if (do_inc)
            next_count = count + COUNT_W'(`STC_COUNT_ONE); // [R1] [R2]
    end

    // Pulse starts with the increment, ends at the next oscillator edge
    always_comb
    begin
        next_pulse = pulse;
        if (do_inc)
            next_pulse = 1'b1; // [R11] [R23]
        else if (osc_edge || mode.sleep)
            next_pulse = 1'b0; // [R23] [R14]
    end

    wire next_int = mode.echo ? (osc_level && !mode.sleep) : next_pulse; // [R13]

    // Only one deferred tick is kept; a second one during the same access is lost
    wire next_pending = hold ? inc_req : 1'b0; // [R4] [R18]

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            count      <= `STC_COUNT_RESET; // [R3]
            pending    <= 1'b0;
            load_state <= stc_pkg::LD_IDLE;
        end
        else
        begin
            count      <= next_count; // [R24]
            pending    <= next_pending;
            load_state <= next_load_state;
        end
    end

    // Mode bits change only on a clock edge, so prescaler sees them settled
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            mode <= '0;
        else
            mode <= next_mode; // [R16]
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            session <= 1'b0;
        else if (wr_session)
            session <= bus_wdata[`STC_SESSION_BIT]; // [R17]
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            osc_level   <= 1'b0;
            crystal_out <= 1'b0;
        end
        else
        begin
            osc_level   <= crystal_in;
            crystal_out <= !crystal_in && !mode.sleep; // [R14]
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pulse   <= 1'b0;
            int_out <= 1'b0;
        end
        else
        begin
            pulse   <= next_pulse;
            int_out <= next_int; // [R11] [R12]
        end
    end

    // Read data
    wire [DATA_W-1:0] status_word = DATA_W'({pulse, session, pending, mode.fast,
                                              mode.echo, mode.sleep, mode.halt});
    wire [DATA_W-1:0] read_mux =
        rd_count   ? DATA_W'(count) :
        rd_status  ? status_word :
        rd_session ? DATA_W'(session) :
        rd_instr   ? DATA_W'(load_state) :
                     '0;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            bus_rdata <= '0;
        else
            bus_rdata <= read_mux; // [R12]
    end

endmodule : stc_core

//--- src/stc_map.svh
// Address map, instruction codes, field positions and divider sizes of the slow tick counter
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

`define STC_ADDR_W          8
`define STC_DATA_W          32

`define STC_OFS_INSTR       8'h00
`define STC_OFS_PARAM       8'h04
`define STC_OFS_SESSION     8'h08
`define STC_OFS_COUNT       8'h0C
`define STC_OFS_STATUS      8'h10

`define STC_CODE_DIV_STOP   8'h11
`define STC_CODE_DIV_RUN    8'h10
`define STC_CODE_SLEEP_ON   8'h21
`define STC_CODE_SLEEP_OFF  8'h20
`define STC_CODE_ECHO_ON    8'h31
`define STC_CODE_ECHO_OFF   8'h30
`define STC_CODE_FAST_ON    8'h41
`define STC_CODE_FAST_OFF   8'h40
`define STC_CODE_LOAD       8'h80

`define STC_COUNT_W         24
`define STC_COUNT_RESET     24'h000000
`define STC_COUNT_ONE       24'h000001
`define STC_HIGH_LSB        16
`define STC_MID_LSB         8
`define STC_LOW_LSB         0

`define STC_ST_HALT         0
`define STC_ST_SLEEP        1
`define STC_ST_ECHO         2
`define STC_ST_FAST         3
`define STC_ST_PENDING      4
`define STC_ST_SESSION      5
`define STC_ST_PULSE        6
`define STC_SESSION_BIT     0

`define STC_S1_BITS         2
`define STC_S2_BITS         13
`define STC_S3_BITS         5

`endif

//--- src/stc_pkg.sv
// Types used by the slow tick counter core: mode bits and load sequencer states
package stc_pkg;

    typedef struct packed
    {
        logic halt;
        logic sleep;
        logic echo;
        logic fast;
    } stc_mode_t;

    typedef enum logic [2:0]
    {
        LD_IDLE,
        LD_HIGH,
        LD_MID,
        LD_LOW,
        LD_DONE
    } stc_load_t;

endpackage : stc_pkg

//--- src/stc_prescaler.sv
// Three stage prescaler from oscillator edges down to the counter tick
`include "stc_map.svh"

module stc_prescaler #(
    parameter int S1_BITS = `STC_S1_BITS,
    parameter int S2_BITS = `STC_S2_BITS,
    parameter int S3_BITS = `STC_S3_BITS
) (
    input  wire logic ref_clk,   // System clock
    input  wire logic reset,     // Synchronous reset, active high
    input  wire logic osc_edge,  // One pulse per oscillator period
    input  wire logic halt,      // Hold stages two and three cleared
    input  wire logic fast,      // Tick once per second
    output logic      tick       // One cycle pulse per count step
);

    logic [S1_BITS-1:0] stage1;
    logic [S2_BITS-1:0] stage2;
    logic [S3_BITS-1:0] stage3;

    wire s1_carry = osc_edge && (&stage1);
    wire s2_carry = s1_carry && (&stage2);
    wire s3_carry = s2_carry && (&stage3);
    wire next_tick = !halt && (fast ? s2_carry : s3_carry);

    // Stage one free-runs so its phase is unknown at a restart
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            stage1 <= '0;
        else if (osc_edge)
            stage1 <= stage1 + 1'b1; // [R7] [R10]
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset || halt)
        begin
            stage2 <= '0; // [R7] [R20]
            stage3 <= '0;
        end
        else
        begin
            if (s1_carry)
                stage2 <= stage2 + 1'b1;
            if (s2_carry)
                stage3 <= stage3 + 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            tick <= 1'b0;
        else
            tick <= next_tick; // [R1] [R9] [R19]
    end

endmodule : stc_prescaler

//--- tb/stc_core_props.sv
// Port-level assertions for the slow tick counter core
`include "stc_map.svh"

module stc_core_props #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic              ref_clk,     // System clock
    input wire logic              reset,       // Synchronous reset
    input wire logic              crystal_in,  // Oscillator level
    input wire logic              crystal_out, // Oscillator drive
    input wire logic              int_out,     // Pulse or echo
    input wire logic [ADDR_W-1:0] bus_addr,    // Register address
    input wire logic [DATA_W-1:0] bus_wdata,   // Write data
    input wire logic              bus_wr,      // Write strobe
    input wire logic              bus_rd,      // Read strobe
    input wire logic [DATA_W-1:0] bus_rdata    // Read data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       halt_q;
    logic       sleep_q;
    logic       echo_q;
    logic       fast_q;
    logic       session_q;
    // Code 00h matches no mode code, so idle cycles leave every mode alone
    wire  [7:0] code   = (bus_wr && bus_addr == `STC_OFS_INSTR) ? bus_wdata[7:0] : 8'h00;
    wire        sess_w = bus_wr && bus_addr == `STC_OFS_SESSION;
    wire        mapped = bus_addr <= `STC_OFS_STATUS && bus_addr[1:0] == 2'h0;

    function automatic logic mode_next(logic cur, logic [7:0] c, logic [7:0] on, logic [7:0] off);
        return (c == on) ? 1'b1 : ((c == off) ? 1'b0 : cur);
    endfunction : mode_next

    always_ff @(posedge ref_clk)
    begin
        halt_q    <= !reset && mode_next(halt_q, code, `STC_CODE_DIV_STOP, `STC_CODE_DIV_RUN);
        sleep_q   <= !reset && mode_next(sleep_q, code, `STC_CODE_SLEEP_ON, `STC_CODE_SLEEP_OFF);
        echo_q    <= !reset && mode_next(echo_q, code, `STC_CODE_ECHO_ON, `STC_CODE_ECHO_OFF);
        fast_q    <= !reset && mode_next(fast_q, code, `STC_CODE_FAST_ON, `STC_CODE_FAST_OFF);
        session_q <= !reset && (sess_w ? bus_wdata[0] : session_q);
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == '0)
        else $error("read data outside answer cycle");
    chk_unmapped_zero: assert property (bus_rd && !mapped |=> bus_rdata == '0)
        else $error("unmapped read not zero");
    chk_status_modes: assert property (bus_rd && bus_addr == `STC_OFS_STATUS |=>
        bus_rdata[3:0] == {fast_q, echo_q, sleep_q, halt_q} && bus_rdata[`STC_ST_SESSION] == session_q)
        else $error("status modes wrong");
    chk_session_read: assert property (bus_rd && bus_addr == `STC_OFS_SESSION |=> bus_rdata[0] == session_q)
        else $error("session readback wrong");
    chk_osc_drive: assert property (!sleep_q && !$past(sleep_q) && !$past(reset) |->
        crystal_out == !$past(crystal_in))
        else $error("oscillator drive wrong");
    chk_sleep_quiet: assert property (sleep_q && $past(sleep_q) |-> !crystal_out && !int_out)
        else $error("activity in deep sleep");
    // The pin level passes the edge-detect register and then the output register
    chk_echo_follow: assert property (echo_q && $past(echo_q) && !sleep_q && !$past(sleep_q)
        && !$past(reset) |-> int_out == $past(crystal_in, 2))
        else $error("echo not following oscillator");
    chk_session_freeze: assert property (session_q && $past(session_q) && !echo_q && !$past(echo_q)
        |-> !$rose(int_out))
        else $error("pulse during open access");

    cov_pulse: cover property ($rose(int_out) && !echo_q);
    cov_sleep_read: cover property (sleep_q && bus_rd);
    cov_session_end: cover property (session_q ##1 !session_q);
endmodule : stc_core_props

bind stc_core stc_core_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
    .ref_clk(ref_clk), .reset(reset), .crystal_in(crystal_in), .crystal_out(crystal_out),
    .int_out(int_out), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata)
);

//--- tb/stc_osc_model.sv
// Crystal stand-in driving the oscillator input
module stc_osc_model (
    input wire logic ref_clk,    // System clock
    output logic     crystal_in  // Oscillator level
);
    timeunit 1ns;
    timeprecision 1ns;
    // Two clocks per period: fastest rate the core can edge-detect, keeps a fast tick near 65k cycles
    initial crystal_in = 1'b0;
    always @(posedge ref_clk) crystal_in <= !crystal_in;
endmodule : stc_osc_model

//--- tb/test_slow_tick_counter_core.sv
// Self-checking bench for the slow tick counter core
`include "stc_map.svh"

module test_slow_tick_counter_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk;
    logic        reset;
    logic        crystal_in;
    logic        crystal_out;
    logic        int_out;
    logic [7:0]  bus_addr;
    logic [31:0] bus_wdata;
    logic        bus_wr;
    logic        bus_rd;
    logic [31:0] bus_rdata;
    logic [31:0] rd_val;
    logic        seen;
    int          i;
    int          highs;
    int          n_errors;
    int          n_tests;

    stc_core dut (.ref_clk(ref_clk), .reset(reset), .crystal_in(crystal_in), .crystal_out(crystal_out),
        .int_out(int_out), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata));
    stc_osc_model u_osc (.ref_clk(ref_clk), .crystal_in(crystal_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = !ref_clk;
    end

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        bus_wr    <= 1'b1;
        bus_addr  <= addr;
        bus_wdata <= data;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask : wr

    task automatic instr(input logic [7:0] c);
        wr(`STC_OFS_INSTR, {24'h000000, c});
    endtask : instr

    task automatic rd(input logic [7:0] addr);
        @(posedge ref_clk);
        bus_rd   <= 1'b1;
        bus_addr <= addr;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        rd_val = bus_rdata;
    endtask : rd

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask : check

    task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp, input string what);
        rd(addr);
        check(rd_val, exp, what);
    endtask : rd_check

    task automatic complete_run();
        $display("compares %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (80000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end

    initial
    begin
        reset     = 1'b1;
        bus_addr  = 8'h00;
        bus_wdata = 32'h00000000;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        rd_check(`STC_OFS_COUNT, 32'h00000000, "count after reset");
        rd_check(8'h14, 32'h00000000, "unmapped read");
        instr(`STC_CODE_DIV_STOP);
        instr(`STC_CODE_FAST_ON);
        rd_check(`STC_OFS_STATUS, 32'h00000009, "halt and fast");
        instr(`STC_CODE_LOAD);
        wr(`STC_OFS_PARAM, 32'h000000A9);
        instr(`STC_CODE_FAST_ON);
        rd_check(`STC_OFS_COUNT, 32'h00A90000, "partial load");
        instr(`STC_CODE_LOAD);
        for (i = 0; i < 3; i++) wr(`STC_OFS_PARAM, 32'h000000FF);
        repeat (300) @(posedge ref_clk);
        rd_check(`STC_OFS_COUNT, 32'h00FFFFFF, "load held while halted");
        rd_check(`STC_OFS_INSTR, 32'h00000004, "load sequence done");
        instr(`STC_CODE_ECHO_ON);
        highs = 0;
        repeat (8)
        begin
            @(posedge ref_clk);
            #1;
            highs += int_out;
        end
        check(32'(highs), 32'h00000004, "echo duty");
        instr(`STC_CODE_ECHO_OFF);
        instr(`STC_CODE_SLEEP_ON);
        repeat (3) @(posedge ref_clk);
        #1;
        check({31'h0, crystal_out}, 32'h00000000, "drive in sleep");
        rd_check(`STC_OFS_STATUS, 32'h0000000B, "status in sleep");
        rd_check(`STC_OFS_COUNT, 32'h00FFFFFF, "count in sleep");
        instr(`STC_CODE_SLEEP_OFF);
        instr(`STC_CODE_DIV_RUN);
        // Fast tick is 32768 oscillator edges, two clocks each, less up to three edges of stage one phase
        repeat (65400) @(posedge ref_clk);
        rd_check(`STC_OFS_STATUS, 32'h00000008, "no tick before full period");
        wr(`STC_OFS_SESSION, 32'h00000001);
        rd_val = 32'h00000000;
        for (i = 0; i < 200 && rd_val[4] !== 1'b1; i++) rd(`STC_OFS_STATUS);
        check(rd_val, 32'h00000038, "tick held in access");
        rd_check(`STC_OFS_COUNT, 32'h00FFFFFF, "count frozen");
        wr(`STC_OFS_SESSION, 32'h00000000);
        seen = 1'b0;
        for (i = 0; i < 20 && seen !== 1'b1; i++)
        begin
            @(posedge ref_clk);
            #1;
            seen = int_out;
        end
        check({31'h0, seen}, 32'h00000001, "pulse after access");
        rd_check(`STC_OFS_COUNT, 32'h00000000, "wrapped count");
        instr(`STC_CODE_FAST_OFF);
        rd_check(`STC_OFS_STATUS, 32'h00000000, "fast mode off");
        complete_run();
    end
endmodule : test_slow_tick_counter_core
